// ==== core/lusf_framer.sv ====
`default_nettype none
module lusf_framer #(
  parameter int BASE_DIV = lusf_pkg::BASE_RATE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        stream_enable_cmd_i,
  input  wire logic [31:0] cmd_src_ip_i,
  input  wire logic        udp_port_select_cmd_i,
  input  wire logic [15:0] udp_port_value_i,
  input  wire logic        byte_order_checksum_cmd_i,
  input  wire logic        opt_little_i,
  input  wire logic        opt_checksum_i,
  input  wire logic        payload_size_cmd_i,
  input  wire logic [1:0]  payload_size_code_i,
  input  wire logic        subsample_rate_cmd_i,
  input  wire logic [4:0]  subsample_rate_code_i,
  input  wire logic [2:0]  content_code_i,
  input  wire logic [31:0] x_i,
  input  wire logic [31:0] y_i,
  input  wire logic [31:0] r_i,
  input  wire logic [31:0] theta_i,
  input  wire logic        input_ovld_i,
  input  wire logic        sync_ovld_i,
  input  wire logic        sync_on_i,
  input  wire logic        output_ovld_i,
  input  wire logic        pll_unlock_i,
  input  wire logic        sync_range_i,
  input  wire logic        byte_ready_i,
  output logic             byte_valid_o,
  output logic [7:0]       byte_data_o,
  output logic             byte_first_o,
  output logic             byte_last_o,
  output logic [31:0]      dest_ip_o,
  output logic [15:0]      dest_port_o,
  output logic             checksum_en_o,
  output logic             overrun_o
);

  // ----------------------------------------
  // types and helpers
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_HDR, ST_DATA} lusf_state_e;

  typedef struct packed {
    lusf_state_e  state;
    logic         en;
    logic [31:0]  ip;
    logic [15:0]  port;
    logic         little;
    logic         cksum;
    logic [1:0]   len;
    logic [4:0]   rate;
    logic [2:0]   content;
    logic [6:0]   div;
    logic [31:0]  sub;
    logic [7:0]   count;
    logic [7:0]   status;
    logic [10:0]  fill;
    logic [10:0]  idx;
    logic         valid;
    logic [7:0]   data;
    logic         first;
    logic         last;
    logic         overrun;
  } lusf_state_s;

  function automatic logic [10:0] len_bytes(input logic [1:0] code);
    len_bytes = 11'(lusf_pkg::MAX_DATA_BYTES >> code);
  endfunction

  // byte k of a w-byte word, honouring the byte order
  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] k,
                                      input logic wide, input logic little);
    logic [1:0] sel;
    sel = 2'h0;
    if (wide) begin
      sel = little ? k : 2'(2'h3 - k);
    end else begin
      sel = little ? {1'b0, k[0]} : {1'b0, ~k[0]};
    end
    pick = w[8*sel +: 8];
  endfunction

  // ----------------------------------------
  // sample buffer: one full payload
  // ----------------------------------------
  logic [7:0] buf_mem [lusf_pkg::MAX_DATA_BYTES];
  lusf_state_s s;
  lusf_state_s next_s;
  logic        tick;
  logic        wr_en;
  logic [10:0] wr_addr;
  logic [7:0]  wr_data;
  logic [31:0] hdr;
  logic [2:0]  nch;
  logic        wide;
  logic [31:0] chv;

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      buf_mem[wr_addr[9:0]] <= wr_data;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s  = s;
    wr_en   = 1'b0;
    wr_addr = s.fill;
    wr_data = 8'h00;
    wide    = ~s.content[2];
    tick    = 1'b0;
    chv     = 32'h0;

    // ----------------------------------------
    // channel count and header word
    // ----------------------------------------
    // integer samples take the upper 16 bits of each channel
    case (s.content[1:0])
      2'h0: nch = 3'h1;
      2'h1: nch = 3'h2;
      2'h2: nch = 3'h2;
      default: nch = 3'h4;
    endcase
    hdr = {s.status, 3'h0, s.rate, 2'h0, s.len, 1'b0, s.content, s.count};

    // ----------------------------------------
    // sample tick
    // ----------------------------------------
    // base tick: once every BASE_DIV cycles, 1.25 MHz with the default BASE_DIV at 100 MHz
    next_s.div = (s.div == 7'(BASE_DIV - 1)) ? 7'h0 : 7'(s.div + 7'h1);
    if (s.div == 7'h0) begin
      next_s.sub = s.sub + 32'h1;
      tick = ((s.sub & ((32'h1 << s.rate) - 32'h1)) == 32'h0);
    end

    // ----------------------------------------
    // configuration commands
    // ----------------------------------------
    if (udp_port_select_cmd_i) begin
      next_s.port = udp_port_value_i;
    end

    if (byte_order_checksum_cmd_i) begin
      next_s.little = opt_little_i;
      next_s.cksum  = opt_checksum_i;
    end

    if (payload_size_cmd_i) begin
      next_s.len = payload_size_code_i;
    end

    if (subsample_rate_cmd_i) begin
      next_s.rate = subsample_rate_code_i;
    end

    if (stream_enable_cmd_i) begin
      next_s.ip = cmd_src_ip_i;
    end

    next_s.en = stream_enable_cmd_i | s.en;
    // clear before set: a tick lost in the same cycle stays visible
    if (stream_enable_cmd_i) begin
      next_s.overrun = 1'b0;
    end

    // ----------------------------------------
    // output handshake
    // ----------------------------------------
    if (s.valid && byte_ready_i) begin
      next_s.valid = 1'b0;
      next_s.first = 1'b0;
      next_s.last  = 1'b0;
    end

    // ----------------------------------------
    // packet sequencing
    // ----------------------------------------
    case (s.state)
      ST_IDLE: begin
        next_s.fill = 11'h0;
        if (s.en) begin
          next_s.content = content_code_i;
          next_s.state   = ST_FILL;
        end
      end
      ST_FILL: begin
        if (tick) begin
          if (s.fill == 11'h0) begin
            next_s.status = 8'h0;
            next_s.status[lusf_pkg::ST_OVERLOAD_BIT] = input_ovld_i
              | (sync_ovld_i & sync_on_i) | (output_ovld_i & s.content[2]);
            next_s.status[lusf_pkg::ST_ERROR_BIT] = pll_unlock_i | sync_range_i;
            next_s.status[lusf_pkg::ST_LITTLE_BIT]   = s.little;
            next_s.status[lusf_pkg::ST_CHECKSUM_BIT] = s.cksum;
          end
          next_s.idx  = 11'h0;
          next_s.fill = s.fill;
          next_s.state = ST_DATA;
        end
      end
      default: ;
    endcase

    // ----------------------------------------
    // sample capture
    // ----------------------------------------
    // ST_DATA here is sample capture into the buffer, byte by byte
    if (s.state == ST_DATA && !s.valid) begin
      case (s.idx[3:2])
        2'h0: chv = (nch == 3'h2 && s.content[1]) ? r_i : x_i;
        2'h1: chv = (nch == 3'h2 && s.content[1]) ? theta_i : y_i;
        2'h2: chv = r_i;
        default: chv = theta_i;
      endcase
      wr_en   = 1'b1;
      wr_data = wide ? pick(chv, s.idx[1:0], 1'b1, s.little)
                     : pick({16'h0, chv[31:16]}, s.idx[1:0], 1'b0, s.little);
      next_s.fill  = s.fill + 11'h1;
      if (wide ? (s.idx[1:0] == 2'h3) : s.idx[0]) begin
        next_s.idx = wide ? {s.idx[10:4], s.idx[3:2] + 2'h1, 2'h0}
                          : {s.idx[10:4], s.idx[3:2] + 2'h1, 2'h0};
        if (3'({1'b0, s.idx[3:2]} + 3'h1) == nch) begin
          next_s.state = ST_FILL;
        end
      end else begin
        next_s.idx = s.idx + 11'h1;
      end
      if (s.fill + 11'h1 == len_bytes(s.len)) begin
        next_s.state = ST_HDR;
        next_s.idx   = 11'h0;
      end
      if (tick && s.fill != 11'h0) begin
        next_s.overrun = 1'b1;
      end
    end

    // ----------------------------------------
    // packet emission
    // ----------------------------------------
    // ST_HDR streams 4 header bytes then the buffer
    if (s.state == ST_HDR && (!s.valid || byte_ready_i)) begin
      next_s.valid = 1'b1;
      next_s.first = (s.idx == 11'h0);
      if (s.idx < 11'(lusf_pkg::HDR_BYTES)) begin
        next_s.data = hdr[8*(3 - s.idx[1:0]) +: 8];
      end else begin
        next_s.data = buf_mem[10'(s.idx - 11'(lusf_pkg::HDR_BYTES))];
      end
      next_s.idx  = s.idx + 11'h1;
      if (s.idx == len_bytes(s.len) + 11'(lusf_pkg::HDR_BYTES) - 11'h1) begin
        next_s.last  = 1'b1;
        next_s.count = s.count + 8'h1;
        next_s.fill  = 11'h0;
        next_s.state = ST_IDLE;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.port  <= lusf_pkg::UDP_PORT_DEFAULT;
      s.len   <= lusf_pkg::LEN_1024[1:0];
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs straight from state
  // ----------------------------------------
  assign byte_valid_o  = s.valid;
  assign byte_data_o   = s.data;
  assign byte_first_o  = s.first;
  assign byte_last_o   = s.last;
  assign dest_ip_o     = s.ip;
  assign dest_port_o   = s.port;
  assign checksum_en_o = s.cksum;
  assign overrun_o     = s.overrun;

endmodule
`default_nettype wire

// ==== include/lusf_pkg.sv ====
`default_nettype none
package lusf_pkg;
  // ----------------------------------------
  // header field positions
  // ----------------------------------------
  localparam int HDR_STATUS_LSB  = 24;
  localparam int HDR_RATE_LSB    = 16;
  localparam int HDR_LEN_LSB     = 12;
  localparam int HDR_CONTENT_LSB = 8;
  localparam int HDR_COUNT_LSB   = 0;
  localparam int ST_OVERLOAD_BIT = 0;
  localparam int ST_ERROR_BIT    = 1;
  localparam int ST_LITTLE_BIT   = 4;
  localparam int ST_CHECKSUM_BIT = 5;
  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [15:0] UDP_PORT_DEFAULT = 16'h0749;
  localparam logic [3:0]  LEN_1024         = 4'h0;
  localparam logic [3:0]  LEN_128          = 4'h3;
  localparam logic [2:0]  CONTENT_INT_BIT  = 3'h4;
  localparam logic [4:0]  RATE_MAX_CODE    = 5'h1F;
  localparam int          HDR_BYTES        = 4;
  localparam int          MAX_DATA_BYTES   = 1024;
  // ----------------------------------------
  // timing: base sample rate 1.25 MHz at 100 MHz clock
  // ----------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int BASE_RATE_HZ    = 1_250_000;
  localparam int BASE_RATE_CYCLES = CLK_HZ / BASE_RATE_HZ;
endpackage
`default_nettype wire

// ==== tb/lusf_framer_monitor.sv ====
`default_nettype none
module lusf_framer_monitor (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        udp_port_select_cmd_i,
  input wire logic [15:0] udp_port_value_i,
  input wire logic        byte_ready_i,
  input wire logic        byte_valid_o,
  input wire logic [7:0]  byte_data_o,
  input wire logic        byte_first_o,
  input wire logic        byte_last_o,
  input wire logic [15:0] dest_port_o,
  input wire logic        checksum_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // byte position inside the packet
  // ----
  logic [10:0] idx;
  logic [3:0]  lenc;
  logic [7:0]  prev;
  logic        have;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      idx <= 11'h000;
      lenc <= 4'h0;
      prev <= 8'h00;
      have <= 1'b0;
    end else if (byte_valid_o && byte_ready_i) begin
      idx <= byte_last_o ? 11'h000 : idx + 11'h001;
      if (idx == 11'h002) begin
        lenc <= byte_data_o[7:4];
      end
      if (idx == 11'h003) begin
        prev <= byte_data_o;
        have <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_stall;
    byte_valid_o && !byte_ready_i;
  endsequence
  a_port_reset: assert property (
    $rose(nrst_i) |-> dest_port_o == 16'h0749) else $error("port not default");
  a_port_load: assert property (
    udp_port_select_cmd_i |=> dest_port_o == $past(udp_port_value_i)) else $error("port lost");
  a_stall_hold: assert property (
    s_stall |=> byte_valid_o && $stable(byte_data_o) && $stable(byte_last_o)) else $error("drop");
  a_first_status: assert property (
    byte_valid_o && byte_first_o |-> idx == 11'h000 && byte_data_o[5] == checksum_en_o)
    else $error("bad status byte");
  a_rate_max: assert property (
    byte_valid_o && idx == 11'h001 |-> byte_data_o[7:5] == 3'h0) else $error("rate code");
  a_len_content: assert property (
    byte_valid_o && idx == 11'h002 |-> byte_data_o[7:6] == 2'h0 && !byte_data_o[3])
    else $error("length or content code");
  a_count_step: assert property (
    byte_valid_o && idx == 11'h003 && have |-> byte_data_o == 8'(prev + 8'h01))
    else $error("counter step");
  a_len_bytes: assert property (
    byte_valid_o && byte_last_o |-> idx == 11'h003 + (11'h400 >> lenc[1:0]))
    else $error("packet length");
endmodule
`default_nettype wire

// ==== tb/lusf_host_model.sv ====
`default_nettype none
module lusf_host_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       stall_i,
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_data_i,
  input  wire logic       byte_last_i,
  output logic            byte_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx  [1028];
  logic [7:0] pkt [1028];
  int         fill, pkt_len, pkt_num;
  // ----
  // receiver: stalls at random when asked
  // ----
  initial byte_ready_o = 1'b0;
  always @(negedge clk_i) begin
    byte_ready_o <= nrst_i && !(stall_i && $urandom_range(1, 0) == 0);
  end
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      fill = 0;
      pkt_num = 0;
    end else if (byte_valid_i && byte_ready_o) begin
      rx[fill] = byte_data_i;
      fill++;
      if (byte_last_i) begin
        pkt = rx;
        pkt_len = fill;
        pkt_num++;
        fill = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, nrst_i, stream_enable_cmd_i, udp_port_select_cmd_i, opt_little_i;
  logic        byte_order_checksum_cmd_i, opt_checksum_i, payload_size_cmd_i, stall;
  logic        subsample_rate_cmd_i, input_ovld_i, sync_ovld_i, sync_on_i, output_ovld_i;
  logic        pll_unlock_i, sync_range_i, byte_ready_i, byte_valid_o, byte_first_o;
  logic        byte_last_o, checksum_en_o, overrun_o, ovl;
  logic [1:0]  payload_size_code_i;
  logic [2:0]  content_code_i;
  logic [4:0]  subsample_rate_code_i;
  logic [7:0]  byte_data_o, c0;
  logic [15:0] udp_port_value_i, dest_port_o;
  logic [31:0] cmd_src_ip_i, x_i, y_i, r_i, theta_i, dest_ip_o;
  int          n_mismatch, cmp_count, wt;
  lusf_framer #(.BASE_DIV(4)) lusf_framer_inst (.*);
  lusf_host_model lusf_host_model_inst (.clk_i, .nrst_i, .stall_i(stall),
    .byte_valid_i(byte_valid_o), .byte_data_i(byte_data_o), .byte_last_i(byte_last_o),
    .byte_ready_o(byte_ready_i));
  always #5 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // expected data byte; swap unit is the word size
  // ----
  function automatic logic [7:0] exp_byte(input int i);
    int          ws, nch, k, pos;
    logic [31:0] w;
    logic [31:0] chs [4];
    chs = '{x_i, y_i, r_i, theta_i};
    ws  = content_code_i[2] ? 2 : 4;
    nch = content_code_i[1:0] == 2'h0 ? 1 : content_code_i[1:0] == 2'h3 ? 4 : 2;
    k   = i % (ws * nch);
    w   = chs[k / ws + (content_code_i[1:0] == 2'h2 ? 2 : 0)] >> (ws == 2 ? 16 : 0);
    pos = opt_little_i ? k % ws : ws - 1 - k % ws;
    return w[8 * pos +: 8];
  endfunction
  initial begin
    clk_i = 1'b0;
    {nrst_i, stream_enable_cmd_i, udp_port_select_cmd_i, byte_order_checksum_cmd_i} = '0;
    {payload_size_cmd_i, subsample_rate_cmd_i, n_mismatch, cmp_count} = '0;
    void'($urandom(44296));
    for (int t = 0; t < 8; t++) begin
      {input_ovld_i, sync_ovld_i, sync_on_i, output_ovld_i, pll_unlock_i, sync_range_i} =
        (t == 5) ? 6'h3F : 6'($urandom);
      {x_i, y_i, r_i, theta_i, cmd_src_ip_i} = {$urandom, $urandom, $urandom, $urandom, $urandom};
      udp_port_value_i = 16'($urandom);
      subsample_rate_code_i = 5'($urandom_range(1, 0));
      content_code_i = 3'(t);
      payload_size_code_i = 2'(t);
      {opt_checksum_i, opt_little_i} = 2'(t);
      stall = t > 3;
      nrst_i = 1'b0;
      repeat (8) @(negedge clk_i);
      nrst_i = 1'b1;
      check(dest_port_o, 16'h0749, "reset port");
      {udp_port_select_cmd_i, byte_order_checksum_cmd_i} = {t != 0, 1'b1};
      {payload_size_cmd_i, subsample_rate_cmd_i} = 2'h3;
      @(negedge clk_i);
      {udp_port_select_cmd_i, byte_order_checksum_cmd_i, payload_size_cmd_i} = '0;
      {subsample_rate_cmd_i, stream_enable_cmd_i} = 2'h1;
      @(negedge clk_i);
      stream_enable_cmd_i = 1'b0;
      check(dest_ip_o, cmd_src_ip_i, "ip");
      check(dest_port_o, (t == 0) ? 16'h0749 : udp_port_value_i, "port");
      check(checksum_en_o, opt_checksum_i, "checksum");
      check(overrun_o, 1'b0, "overrun clear");
      ovl = input_ovld_i | (sync_ovld_i & sync_on_i) | (output_ovld_i & content_code_i[2]);
      for (int p = 0; p < 2; p++) begin
        wt = 0;
        while (lusf_host_model_inst.pkt_num == p && wt < 20000) begin
          @(negedge clk_i);
          wt++;
        end
        if (wt == 20000) begin
          n_mismatch++;
          conclude();
        end
        check(32'(lusf_host_model_inst.pkt_len), 4 + (1024 >> payload_size_code_i), "len");
        check(lusf_host_model_inst.pkt[0], {2'h0, opt_checksum_i, opt_little_i, 2'h0,
          pll_unlock_i | sync_range_i, ovl}, "status");
        check(lusf_host_model_inst.pkt[1], subsample_rate_code_i, "rate");
        check(lusf_host_model_inst.pkt[2], {2'h0, payload_size_code_i, 1'b0, content_code_i},
          "code");
        check(lusf_host_model_inst.pkt[3], (p == 0) ? 8'h00 : 8'(c0 + 8'h01), "count");
        c0 = lusf_host_model_inst.pkt[3];
        for (int i = 0; i < lusf_host_model_inst.pkt_len - 4; i++) begin
          check(lusf_host_model_inst.pkt[i + 4], exp_byte(i), "data");
        end
      end
      if (content_code_i[1:0] == 2'h3) check(overrun_o, 1'b1, "overrun");
      $display("test %0d done", t);
    end
    conclude();
  end
endmodule
bind lusf_framer lusf_framer_monitor lusf_framer_monitor_inst (.*);
`default_nettype wire
